/* pag_pkg.sv */
// Constants and carrier types for the autoneg, gigabit and MMD window register slice
// What this block does
// - Parallel detection fault latches high until read
// - Page received latches high until read
// - Local next-page ability always reads one
// - Partner next-page ability follows base page
// - Partner autoneg ability shown; upper bits zero
// - Transmit page fields writable, message and code reset
// - Acknowledge-2 bit writable, comply or not
// - Toggle read-only, inverse of last sent toggle
// - Partner page shown read-only, resets to zero
// - Control test mode field selects transmitter test
// - Manual master/slave enable bit, resets zero
// - Master/slave value used only when manual
// - Port type bit: multi-port or single-port
// - Gigabit full/half advertise bits reset to one
// - Master/slave fault latches, clears when read
// - Resolved role bit, resets to master
// - Local and remote receiver status bits
// - Partner gigabit abilities reflected in status
// - Idle error count clears on read
// - Function field selects window meaning
// - Device address field; middle bits reserved
// - Window loads address or moves data
package pag_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0]  IDX_EXPANSION = 4'h6;
  localparam logic [3:0]  IDX_NP_TX     = 4'h7;
  localparam logic [3:0]  IDX_NP_RX     = 4'h8;
  localparam logic [3:0]  IDX_GIG_CTL   = 4'h9;
  localparam logic [3:0]  IDX_GIG_STAT  = 4'ha;
  localparam logic [3:0]  IDX_MMD_CTL   = 4'hd;
  localparam logic [3:0]  IDX_MMD_DATA  = 4'he;
  // Expansion register bit positions
  localparam int unsigned EXP_PD_FAULT  = 4;
  localparam int unsigned EXP_LP_NP     = 3;
  localparam int unsigned EXP_LOC_NP    = 2;
  localparam int unsigned EXP_PAGE_RX   = 1;
  localparam int unsigned EXP_LP_AN     = 0;
  // Next-page word bit positions, shared by transmit and receive
  localparam int unsigned NP_MORE       = 15;
  localparam int unsigned NP_MSG        = 13;
  localparam int unsigned NP_ACK2       = 12;
  localparam int unsigned NP_TOGGLE     = 11;
  localparam int unsigned NP_CODE_MSB   = 10;
  localparam logic        NP_MSG_RST    = 1'b1;
  localparam logic [10:0] NP_CODE_RST   = 11'h001;
  // Gigabit control field positions and reset of bits 15:8
  localparam int unsigned CTL_TM_MSB    = 15;
  localparam int unsigned CTL_TM_LSB    = 13;
  localparam int unsigned CTL_MS_MAN    = 12;
  localparam int unsigned CTL_MS_VAL    = 11;
  localparam int unsigned CTL_PORT      = 10;
  localparam int unsigned CTL_ADV_FD    = 9;
  localparam int unsigned CTL_ADV_HD    = 8;
  localparam logic [7:0]  CTL_HI_RST    = 8'h03;
  // Gigabit status positions
  localparam int unsigned ST_MS_FAULT   = 15;
  localparam int unsigned ST_MS_RES     = 14;
  localparam logic        ST_MS_RES_RST = 1'b1;
  localparam logic [7:0]  IDLE_CNT_MAX  = 8'hff;
  // MMD control positions
  localparam int unsigned MMD_FN_MSB    = 15;
  localparam int unsigned MMD_FN_LSB    = 14;
  localparam int unsigned MMD_DEV_MSB   = 4;

  // Transmitter test modes; codes above four are reserved
  typedef enum logic [2:0] {
    TM_NORMAL = 3'h0, TM_WAVEFORM = 3'h1, TM_JIT_MASTER = 3'h2, TM_JIT_SLAVE = 3'h3, TM_DISTORTION = 3'h4
  } pag_test_mode_type;
  // Meaning of the window register
  typedef enum logic [1:0] {
    MMD_FN_ADDR = 2'h0, MMD_FN_DATA = 2'h1, MMD_FN_INC_RW = 2'h2, MMD_FN_INC_W = 2'h3
  } pag_mmd_fn_type;

  // Inputs from the negotiation engine
  typedef struct packed {
    logic        pd_fault;    // Parallel detection fault event
    logic        lp_np_able;  // Partner base page shows next-page ability
    logic        lp_an_able;  // Partner does auto-negotiation
    logic        page_rx;     // New page arrived, pulse
    logic [15:0] rx_page;     // Page word, valid with page_rx
    logic        page_tx;     // Outgoing page sent, pulse
  } pag_an_in_type;
  // Inputs from the gigabit PMA/PCS
  typedef struct packed {
    logic ms_fault;           // Master/slave configuration fault event
    logic resolved_master;    // Resolved role, level
    logic local_rx_ok;        // Local receiver status
    logic remote_rx_ok;       // Remote receiver status
    logic lp_fd;              // Partner gigabit full duplex
    logic lp_hd;              // Partner gigabit half duplex
    logic idle_err;           // Idle error, pulse
  } pag_gig_in_type;
  // Gigabit control outputs
  typedef struct packed {
    pag_test_mode_type test_mode;     // Reserved codes show as normal
    logic              ms_manual;     // Manual master/slave selection
    logic              ms_force_master; // Master chosen, gated by manual
    logic              multi_port;    // Port type
    logic              adv_fd;        // Advertise full duplex
    logic              adv_hd;        // Advertise half duplex
  } pag_gig_ctl_type;
  // Committed access to the MMD space
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  dev_addr;
    logic [15:0] reg_addr;
    logic [15:0] wdata;
  } pag_mmd_req_type;
endpackage : pag_pkg

/* pag_regs.sv */
// APB register slice: autoneg expansion, next pages, gigabit control/status, MMD window
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
module pag_regs #(
  parameter int unsigned ADDR_W = 8               // APB address width
) (
  input  wire logic                     core_clk,      // 250 MHz
  input  wire logic                     rst_n,         // Async, active low
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire pag_pkg::pag_an_in_type   an_in,
  input  wire pag_pkg::pag_gig_in_type  gig_in,
  output pag_pkg::pag_gig_ctl_type      gig_ctl,
  output logic      [15:0]              np_tx_word,    // Outgoing next page
  output logic      [4:0]               mmd_dev_now,   // Lookup device address
  output logic      [15:0]              mmd_addr_now,  // Lookup register address
  input  wire logic [15:0]              mmd_rdata,     // Lookup result, same cycle
  output pag_pkg::pag_mmd_req_type      mmd_req
);

  // Map a byte address to a register index; 4'hf means unmapped
  function automatic logic [3:0] pag_decode(input logic [ADDR_W-1:0] a);
    logic [3:0] idx;
    idx = 4'hf;
    if (a[1:0] == 2'h0 && (a >> 6) == '0) begin
      idx = a[5:2];
    end
    unique case (idx)
      pag_pkg::IDX_EXPANSION, pag_pkg::IDX_NP_TX, pag_pkg::IDX_NP_RX, pag_pkg::IDX_GIG_CTL,
      pag_pkg::IDX_GIG_STAT, pag_pkg::IDX_MMD_CTL, pag_pkg::IDX_MMD_DATA: pag_decode = idx;
      default: pag_decode = 4'hf;
    endcase
  endfunction : pag_decode

  logic [3:0]  idx;        // Decoded register index
  logic        rd_done;    // Read completes at this edge
  logic        wr_done;    // Write completes at this edge
  logic [15:0] rd_mux;     // Live read value
  logic [15:0] snap_q;     // Value handed to the bus in this transfer

  // Expansion state
  logic        pd_fault_q, page_rx_q, lp_np_q, lp_an_q;
  // Transmit page state
  logic        np_more_q, np_msg_q, np_ack2_q, np_toggle_q;
  logic [10:0] np_code_q;
  // Received page
  logic [15:0] np_rx_q;
  // Control bits 15:8
  logic [7:0]  ctl_q;
  // Status state
  logic        ms_fault_q, ms_res_q, lrx_q, rrx_q, lpfd_q, lphd_q;
  logic [7:0]  idle_cnt_q;
  // MMD window state
  pag_pkg::pag_mmd_fn_type mmd_fn_q;
  logic [4:0]  mmd_dev_q;
  logic [15:0] mmd_addr_q;
  logic        win_data;   // Data access through the window completes
  logic        win_inc;    // That access post-increments

  assign idx     = pag_decode(paddr);
  assign rd_done = psel & penable & ~pwrite;
  assign wr_done = psel & penable & pwrite;

  // Zero wait states: data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (idx == 4'hf);
  assign prdata  = {16'h0000, snap_q};

  // Live read multiplexer
  always_comb begin
    rd_mux = 16'h0000;
    unique case (idx)
      pag_pkg::IDX_EXPANSION: begin
        rd_mux[pag_pkg::EXP_PD_FAULT] = pd_fault_q;
        rd_mux[pag_pkg::EXP_LP_NP]    = lp_np_q;
        rd_mux[pag_pkg::EXP_LOC_NP]   = 1'b1;
        rd_mux[pag_pkg::EXP_PAGE_RX]  = page_rx_q;
        rd_mux[pag_pkg::EXP_LP_AN]    = lp_an_q;
      end
      pag_pkg::IDX_NP_TX:    rd_mux = np_tx_word;
      pag_pkg::IDX_NP_RX:    rd_mux = np_rx_q;
      pag_pkg::IDX_GIG_CTL:  rd_mux = {ctl_q, 8'h00};
      pag_pkg::IDX_GIG_STAT: rd_mux = {ms_fault_q, ms_res_q, lrx_q, rrx_q, lpfd_q, lphd_q, 2'h0, idle_cnt_q};
      pag_pkg::IDX_MMD_CTL:  rd_mux = {mmd_fn_q, 9'h000, mmd_dev_q};
      pag_pkg::IDX_MMD_DATA: rd_mux = (mmd_fn_q == pag_pkg::MMD_FN_ADDR) ? mmd_addr_q : mmd_rdata;
      default:               rd_mux = 16'h0000;
    endcase
  end

  // Snapshot in the setup cycle; read-clear uses exactly these bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= 16'h0000;
    end else if (psel & ~penable) begin
      snap_q <= rd_mux;
    end
  end

  // Expansion latches: an event in the clearing cycle wins, and bits
  // the reader never saw are not cleared
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_fault_q <= 1'b0;
      page_rx_q  <= 1'b0;
      lp_np_q    <= 1'b0;
      lp_an_q    <= 1'b0;
    end else begin
      pd_fault_q <= an_in.pd_fault | (pd_fault_q &
                    ~(rd_done & (idx == pag_pkg::IDX_EXPANSION) & snap_q[pag_pkg::EXP_PD_FAULT]));
      page_rx_q  <= an_in.page_rx | (page_rx_q &
                    ~(rd_done & (idx == pag_pkg::IDX_EXPANSION) & snap_q[pag_pkg::EXP_PAGE_RX]));
      lp_np_q    <= an_in.lp_np_able;
      lp_an_q    <= an_in.lp_an_able;
    end
  end

  // Transmit page fields writable by software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      np_more_q <= 1'b0;
      np_msg_q  <= pag_pkg::NP_MSG_RST;
      np_ack2_q <= 1'b0;
      np_code_q <= pag_pkg::NP_CODE_RST;
    end else if (wr_done && idx == pag_pkg::IDX_NP_TX) begin
      np_more_q <= pwdata[pag_pkg::NP_MORE];
      np_msg_q  <= pwdata[pag_pkg::NP_MSG];
      np_ack2_q <= pwdata[pag_pkg::NP_ACK2];
      np_code_q <= pwdata[pag_pkg::NP_CODE_MSB:0];
    end
  end

  // Toggle flips with each sent page; software cannot write it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      np_toggle_q <= 1'b0;
    end else if (an_in.page_tx) begin
      np_toggle_q <= ~np_toggle_q;
    end
  end
  assign np_tx_word = {np_more_q, 1'b0, np_msg_q, np_ack2_q, np_toggle_q, np_code_q};

  // Partner page captured whole on arrival
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      np_rx_q <= 16'h0000;
    end else if (an_in.page_rx) begin
      np_rx_q <= an_in.rx_page;
    end
  end

  // Gigabit control, bits 15:8 only; low byte reserved
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= pag_pkg::CTL_HI_RST;
    end else if (wr_done && idx == pag_pkg::IDX_GIG_CTL) begin
      ctl_q <= pwdata[15:8];
    end
  end

  // Control outputs; a reserved test code would drive the line as normal
  always_comb begin
    gig_ctl = '0;
    if (ctl_q[pag_pkg::CTL_TM_MSB-8:pag_pkg::CTL_TM_LSB-8] <= 3'h4) begin
      gig_ctl.test_mode = pag_pkg::pag_test_mode_type'(ctl_q[pag_pkg::CTL_TM_MSB-8:pag_pkg::CTL_TM_LSB-8]);
    end else begin
      gig_ctl.test_mode = pag_pkg::TM_NORMAL;
    end
    gig_ctl.ms_manual       = ctl_q[pag_pkg::CTL_MS_MAN-8];
    gig_ctl.ms_force_master = ctl_q[pag_pkg::CTL_MS_MAN-8] & ctl_q[pag_pkg::CTL_MS_VAL-8];
    gig_ctl.multi_port      = ctl_q[pag_pkg::CTL_PORT-8];
    gig_ctl.adv_fd          = ctl_q[pag_pkg::CTL_ADV_FD-8];
    gig_ctl.adv_hd          = ctl_q[pag_pkg::CTL_ADV_HD-8];
  end

  // Gigabit status levels and fault latch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_fault_q <= 1'b0;
      ms_res_q   <= pag_pkg::ST_MS_RES_RST;
      lrx_q      <= 1'b0;
      rrx_q      <= 1'b0;
      lpfd_q     <= 1'b0;
      lphd_q     <= 1'b0;
    end else begin
      ms_fault_q <= gig_in.ms_fault | (ms_fault_q &
                    ~(rd_done & (idx == pag_pkg::IDX_GIG_STAT) & snap_q[pag_pkg::ST_MS_FAULT]));
      ms_res_q   <= gig_in.resolved_master;
      lrx_q      <= gig_in.local_rx_ok;
      rrx_q      <= gig_in.remote_rx_ok;
      lpfd_q     <= gig_in.lp_fd;
      lphd_q     <= gig_in.lp_hd;
    end
  end

  // Idle error count saturates; a read removes only what it returned,
  // so errors between setup and access are kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 8'h00;
    end else if (rd_done && idx == pag_pkg::IDX_GIG_STAT) begin
      idle_cnt_q <= idle_cnt_q - snap_q[7:0] + {7'h00, gig_in.idle_err};
    end else if (gig_in.idle_err && idle_cnt_q != pag_pkg::IDLE_CNT_MAX) begin
      idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  // MMD control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mmd_fn_q  <= pag_pkg::MMD_FN_ADDR;
      mmd_dev_q <= 5'h00;
    end else if (wr_done && idx == pag_pkg::IDX_MMD_CTL) begin
      mmd_fn_q  <= pag_pkg::pag_mmd_fn_type'(pwdata[pag_pkg::MMD_FN_MSB:pag_pkg::MMD_FN_LSB]);
      mmd_dev_q <= pwdata[pag_pkg::MMD_DEV_MSB:0];
    end
  end

  assign win_data = psel & penable & (idx == pag_pkg::IDX_MMD_DATA) & (mmd_fn_q != pag_pkg::MMD_FN_ADDR);
  assign win_inc  = win_data & ((mmd_fn_q == pag_pkg::MMD_FN_INC_RW) | ((mmd_fn_q == pag_pkg::MMD_FN_INC_W) & pwrite));

  // Stored MMD register address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mmd_addr_q <= 16'h0000;
    end else if (wr_done && idx == pag_pkg::IDX_MMD_DATA && mmd_fn_q == pag_pkg::MMD_FN_ADDR) begin
      mmd_addr_q <= pwdata[15:0];
    end else if (win_inc) begin
      mmd_addr_q <= mmd_addr_q + 16'h0001;
    end
  end
  assign mmd_dev_now  = mmd_dev_q;
  assign mmd_addr_now = mmd_addr_q;

  // Committed access carries the address before any increment
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mmd_req <= '0;
    end else begin
      mmd_req.valid    <= win_data;
      mmd_req.write    <= pwrite;
      mmd_req.dev_addr <= mmd_dev_q;
      mmd_req.reg_addr <= mmd_addr_q;
      mmd_req.wdata    <= pwdata[15:0];
    end
  end

  chk_pd_fault_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    an_in.pd_fault |=> pd_fault_q) else $error("parallel fault not latched");
  chk_page_rx_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    an_in.page_rx |=> page_rx_q && np_rx_q == $past(an_in.rx_page)) else $error("page not captured");
  chk_exp_fixed_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx == pag_pkg::IDX_EXPANSION |-> rd_mux[15:5] == 11'h000 && rd_mux[2]) else $error("expansion fixed bits");
  chk_toggle_flip: assert property (@(posedge core_clk) disable iff (!rst_n)
    an_in.page_tx |=> np_tx_word[11] != $past(np_tx_word[11])) else $error("toggle did not flip");
  chk_np_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_done && idx == pag_pkg::IDX_NP_TX |=> np_tx_word[10:0] == $past(pwdata[10:0]) &&
    np_tx_word[15] == $past(pwdata[15])) else $error("transmit page write lost");
  chk_manual_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    !gig_ctl.ms_manual |-> !gig_ctl.ms_force_master) else $error("master forced without manual");
  chk_fault_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_done && idx == pag_pkg::IDX_GIG_STAT && snap_q[15] && !gig_in.ms_fault |=> !ms_fault_q)
    else $error("fault not cleared by read");
  chk_event_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_done && idx == pag_pkg::IDX_EXPANSION && an_in.page_rx |=> page_rx_q) else $error("event lost on read");
  chk_idle_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    gig_in.idle_err && !rd_done && idle_cnt_q < 8'h80 |=> idle_cnt_q == $past(idle_cnt_q) + 8'h01)
    else $error("idle error not counted");
  chk_addr_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_done && idx == pag_pkg::IDX_MMD_DATA && mmd_fn_q == pag_pkg::MMD_FN_ADDR
    |=> mmd_addr_q == $past(pwdata[15:0]) && !mmd_req.valid) else $error("mmd address not loaded");
  chk_addr_inc: assert property (@(posedge core_clk) disable iff (!rst_n)
    win_inc |=> mmd_addr_q == $past(mmd_addr_q) + 16'h0001 && mmd_req.reg_addr == $past(mmd_addr_q))
    else $error("mmd address not advanced");

  // Configuration fault latch sets on the event
  chk_ms_fault_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    gig_in.ms_fault |=> ms_fault_q) else $error("master/slave fault not latched");

  // A read that returned the fault clears it when no new event
  chk_pd_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_done && idx == pag_pkg::IDX_EXPANSION && snap_q[pag_pkg::EXP_PD_FAULT] && !an_in.pd_fault
    |=> !pd_fault_q) else $error("parallel fault not cleared");

  // Reserved test codes must never reach the transmitter
  chk_ctl_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctl_q[pag_pkg::CTL_TM_MSB-8:pag_pkg::CTL_TM_LSB-8] > 3'h4 |-> gig_ctl.test_mode == pag_pkg::TM_NORMAL)
    else $error("reserved test mode driven");

  // Control write lands at the access edge
  chk_ctl_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_done && idx == pag_pkg::IDX_GIG_CTL |=> ctl_q == $past(pwdata[15:8])) else $error("control write lost");

  // Receiver status follows one cycle late
  chk_rx_status_levels: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> lrx_q == $past(gig_in.local_rx_ok) && rrx_q == $past(gig_in.remote_rx_ok))
    else $error("receiver status not followed");

  // Partner abilities follow one cycle late
  chk_partner_abilities: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> lpfd_q == $past(gig_in.lp_fd) && lphd_q == $past(gig_in.lp_hd))
    else $error("partner ability not followed");

  // Stick at the ceiling; a wrap would hide a burst of errors
  chk_idle_saturates: assert property (@(posedge core_clk) disable iff (!rst_n)
    idle_cnt_q == pag_pkg::IDLE_CNT_MAX && !rd_done |=> idle_cnt_q == pag_pkg::IDLE_CNT_MAX)
    else $error("idle counter wrapped");

  // Data access through the window commits one request
  chk_mmd_req_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    win_data |=> mmd_req.valid && mmd_req.write == $past(pwrite) && mmd_req.dev_addr == $past(mmd_dev_q))
    else $error("mmd request not issued");

  // Toggle moves only with a sent page
  chk_toggle_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !an_in.page_tx |=> np_tx_word[pag_pkg::NP_TOGGLE] == $past(np_tx_word[pag_pkg::NP_TOGGLE]))
    else $error("toggle moved without a page");

endmodule : pag_regs

/* pag_mmd_space.sv */
// Partner model: the MMD register space behind the window
`timescale 1ns/1ns
module pag_mmd_space (
  input  wire logic                     core_clk,
  input  wire logic [4:0]               mmd_dev_now,
  input  wire logic [15:0]              mmd_addr_now,
  output logic      [15:0]              mmd_rdata,
  input  wire pag_pkg::pag_mmd_req_type mmd_req
);
  // Sixteen words of device 3; upper address bits alias
  logic [15:0] mem_q [16];

  // Known pattern so reads can be predicted
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 16'ha500 + 16'(i);
    end
  end

  // lookup of addressed register
  // Other devices answer the inverse, so a wrong device shows
  assign mmd_rdata = (mmd_dev_now == 5'h03) ? mem_q[mmd_addr_now[3:0]] : ~mem_q[mmd_addr_now[3:0]];

  always @(posedge core_clk) begin
    if (mmd_req.valid && mmd_req.write && mmd_req.dev_addr == 5'h03) begin
      mem_q[mmd_req.reg_addr[3:0]] <= mmd_req.wdata;
    end
  end
endmodule : pag_mmd_space

/* pag_regs_tb.sv */
// Self-checking bench for the autoneg, gigabit and MMD window slice
`timescale 1ns/1ns
module pag_regs_tb;
  logic                     core_clk;     // 250 MHz
  logic                     rst_n;        // Active low
  logic                     psel;         // APB select
  logic                     penable;      // APB access phase
  logic                     pwrite;       // APB direction
  logic [7:0]               paddr;        // Byte address
  logic [31:0]              pwdata;       // Write data
  logic [31:0]              prdata;       // Read data
  logic                     pready;       // Slave ready
  logic                     pslverr;      // Slave error
  pag_pkg::pag_an_in_type   an_in;        // Negotiation events
  pag_pkg::pag_gig_in_type  gig_in;       // PMA/PCS status
  pag_pkg::pag_gig_ctl_type gig_ctl;      // Control outputs
  pag_pkg::pag_mmd_req_type mmd_req;      // MMD commits
  logic [15:0]              np_tx_word;   // Outgoing page
  logic [15:0]              mmd_addr_now; // Lookup address
  logic [15:0]              mmd_rdata;    // Lookup data
  logic [4:0]               mmd_dev_now;  // Lookup device
  logic [31:0]              rd;           // Last read data
  logic                     err;          // Last error flag
  int                       fail_count = 0;
  int                       compares = 0;
  int                       cyc = 0;      // Timeout counter

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  pag_regs #(.ADDR_W(8)) i_pag_regs (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .an_in(an_in), .gig_in(gig_in), .gig_ctl(gig_ctl), .np_tx_word(np_tx_word), .mmd_dev_now(mmd_dev_now),
    .mmd_addr_now(mmd_addr_now), .mmd_rdata(mmd_rdata), .mmd_req(mmd_req));

  pag_mmd_space i_pag_mmd_space (.core_clk(core_clk), .mmd_dev_now(mmd_dev_now),
    .mmd_addr_now(mmd_addr_now), .mmd_rdata(mmd_rdata), .mmd_req(mmd_req));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, never assumes its timing
  task automatic apb(input logic w, input logic [3:0] idx, input logic [15:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  // Read a register and compare its word
  task automatic rdx(input logic [3:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask : rdx

  // Holds an input for n cycles, then lets it land
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  // Reset values and refused accesses
  task automatic t_reset;
    rdx(4'h6, 16'h0004);
    rdx(4'h7, 16'h2001);
    rdx(4'h8, 16'h0000);
    rdx(4'h9, 16'h0300);
    rdx(4'ha, 16'h4000);
    rdx(4'hd, 16'h0000);
    apb(1'b0, 4'h0, 16'h0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset

  // Latched expansion bits and partner page
  task automatic t_expansion;
    @(posedge core_clk);
    an_in.lp_np_able <= 1'b1;
    an_in.lp_an_able <= 1'b1;
    an_in.pd_fault <= 1'b1;
    an_in.page_rx <= 1'b1;
    an_in.rx_page <= 16'hd5aa;
    @(posedge core_clk);
    an_in.pd_fault <= 1'b0;
    an_in.page_rx <= 1'b0;
    an_in.rx_page <= 16'h2a55;
    settle(2);
    rdx(4'h6, 16'h001f);
    rdx(4'h6, 16'h000d);
    wr(4'h6, 16'hffff);
    rdx(4'h6, 16'h000d);
    rdx(4'h8, 16'hd5aa);
    // Page event held across a read survives it
    @(posedge core_clk);
    an_in.page_rx <= 1'b1;
    rdx(4'h6, 16'h000f);
    an_in.page_rx <= 1'b0;
    rdx(4'h6, 16'h000f);
    rdx(4'h6, 16'h000d);
    rdx(4'h8, 16'h2a55);
    $display("test expansion done");
  endtask : t_expansion

  // Transmit page fields, toggle and acknowledge-2
  task automatic t_next_page;
    wr(4'h7, 16'hffff);
    settle(0);
    chk({16'h0, np_tx_word}, 32'h0000_b7ff);
    @(posedge core_clk);
    an_in.page_tx <= 1'b1;
    @(posedge core_clk);
    an_in.page_tx <= 1'b0;
    settle(1);
    rdx(4'h7, 16'hbfff);
    wr(4'h7, 16'h0000);
    rdx(4'h7, 16'h0800);
    $display("test next page done");
  endtask : t_next_page

  // Every test mode code, manual role and advertise bits
  task automatic t_gig_ctl;
    for (int i = 0; i < 8; i++) begin
      wr(4'h9, {3'(i), 13'h1c00});
      settle(0);
      chk({24'h0, gig_ctl}, {24'h0, (i < 5) ? 3'(i) : 3'h0, 5'h1c});
      rdx(4'h9, {3'(i), 13'h1c00});
    end
    wr(4'h9, 16'h0bff);
    settle(0);
    chk({24'h0, gig_ctl}, 32'h0000_0003);
    rdx(4'h9, 16'h0b00);
    $display("test gigabit control done");
  endtask : t_gig_ctl

  // Fault latch, levels and idle error counter
  task automatic t_gig_status;
    @(posedge core_clk);
    gig_in.resolved_master <= 1'b0;
    gig_in.local_rx_ok <= 1'b1;
    gig_in.remote_rx_ok <= 1'b1;
    gig_in.lp_fd <= 1'b1;
    gig_in.lp_hd <= 1'b1;
    gig_in.ms_fault <= 1'b1;
    gig_in.idle_err <= 1'b1;
    @(posedge core_clk);
    gig_in.ms_fault <= 1'b0;
    repeat (2) @(posedge core_clk);
    gig_in.idle_err <= 1'b0;
    settle(2);
    rdx(4'ha, 16'hbc03);
    rdx(4'ha, 16'h3c00);
    // Errors past the ceiling must not wrap the count
    @(posedge core_clk);
    gig_in.idle_err <= 1'b1;
    repeat (300) @(posedge core_clk);
    gig_in.idle_err <= 1'b0;
    settle(1);
    rdx(4'ha, 16'h3cff);
    rdx(4'ha, 16'h3c00);
    $display("test gigabit status done");
  endtask : t_gig_status

  // Window functions: address load, both increment modes, plain data
  task automatic t_mmd;
    wr(4'hd, 16'h0003);
    wr(4'he, 16'h0010);
    wr(4'hd, 16'h8003);
    rdx(4'he, 16'ha500);
    rdx(4'he, 16'ha501);
    wr(4'hd, 16'hc003);
    wr(4'he, 16'h1234);
    rdx(4'he, 16'ha503);
    rdx(4'he, 16'ha503);
    wr(4'hd, 16'h0003);
    wr(4'he, 16'h0012);
    wr(4'hd, 16'h4003);
    rdx(4'he, 16'h1234);
    rdx(4'he, 16'h1234);
    chk({16'h0, mmd_addr_now}, 32'h0000_0012);
    wr(4'hd, 16'hffff);
    rdx(4'hd, 16'hc01f);
    $display("test mmd window done");
  endtask : t_mmd

  // Verdict and end of run
  task automatic end_of_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Hang guard: the run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    an_in = '0;
    gig_in = '0;
    gig_in.resolved_master = 1'b1;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_expansion();
    t_next_page();
    t_gig_ctl();
    t_gig_status();
    t_mmd();
    end_of_test();
  end
endmodule : pag_regs_tb
